// *** hw/uic_pkg.sv ***
// Shared constants for the universal input conditioner.
package uic_pkg;
    // Geometry of the block.
    localparam int unsigned NUM_INPUTS = 8;
    localparam int unsigned LINKS      = 24;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned SLOT_W     = 10;

    // Per-input register fields, address = {0, input[2:0], field[3:0]}.
    localparam logic [3:0] F_RANGE     = 4'h0;
    localparam logic [3:0] F_OFFSET    = 4'h1;
    localparam logic [3:0] F_SCALE     = 4'h2;
    localparam logic [3:0] F_CLAMP_MAX = 4'h3;
    localparam logic [3:0] F_CLAMP_MIN = 4'h4;
    localparam logic [3:0] F_HI1       = 4'h5;
    localparam logic [3:0] F_LO1       = 4'h6;
    localparam logic [3:0] F_HI2       = 4'h7;
    localparam logic [3:0] F_LO2       = 4'h8;
    localparam logic [3:0] F_THRESH    = 4'h9;
    localparam logic [3:0] F_LIN_DEST  = 4'hA;
    localparam logic [3:0] F_OP1_DEST  = 4'hB;
    localparam logic [3:0] F_OP2_DEST  = 4'hC;
    localparam logic [3:0] F_DYN_MASK  = 4'hD;

    // Global registers.
    localparam logic [7:0] A_CTRL      = 8'h80;
    localparam logic [7:0] A_STATUS    = 8'h81;
    localparam logic [7:0] A_MASK      = 8'h82;
    localparam logic [7:0] A_LOGIC     = 8'h83;
    localparam logic [7:0] A_CONFLICT  = 8'h84;

    // Status bit positions.
    localparam int unsigned ST_DUP   = 0;
    localparam int unsigned ST_SCAN  = 1;
    localparam int unsigned ST_CHECK = 2;
    localparam int unsigned ST_W     = 3;

    // Slot that disconnects a destination link.
    localparam logic [9:0] SLOT_DISCONNECT = 10'h190;
    localparam logic [9:0] SLOT_MAX        = 10'h2D0;

    // Input ranges in millivolts and 2^30 / range for the scaling divide.
    localparam logic signed [15:0] RANGE_MV [4] =
        '{16'sh1388, 16'sh2710, 16'sh4E20, 16'sh7530};
    localparam logic signed [19:0] RANGE_RECIP [4] =
        '{20'sh346DC, 20'sh1A36E, 20'sh0D1B7, 20'sh08BCF};
    localparam int unsigned RECIP_SHIFT = 30;

    // Reset values, values in 0.01 % units, offset and threshold in mV.
    localparam logic [1:0]         RANGE_RST = 2'h1;
    localparam logic signed [15:0] SCALE_RST = 16'sh2710;
    localparam logic signed [15:0] MAX_RST   = 16'sh2710;
    localparam logic signed [15:0] MIN_RST   = -16'sh2710;
    localparam logic signed [15:0] HI_RST    = 16'sh0001;
    localparam logic signed [15:0] ZERO_RST  = 16'sh0000;
    localparam logic [9:0] LIN_DEST_RST [8] = '{10'h03F, 10'h190, 10'h01A,
        10'h05A, 10'h059, 10'h190, 10'h190, 10'h190};
    localparam logic [9:0] OP1_DEST_RST [8] = '{10'h190, 10'h190, 10'h190,
        10'h190, 10'h190, 10'h034, 10'h030, 10'h031};

    // Scan states, Gray coded from SC_SAMPLE to SC_OP2; the wrap back to SC_SAMPLE changes all three bits.
    typedef enum logic [2:0] {
        SC_SAMPLE = 3'b000,
        SC_LIN    = 3'b001,
        SC_FETCH1 = 3'b011,
        SC_OP1    = 3'b010,
        SC_FETCH2 = 3'b110,
        SC_OP2    = 3'b111
    } uic_scan_t;
endpackage : uic_pkg

// *** hw/uic_top.sv ***
// Eight-input conditioner with linear and logic paths and conflict check.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
// Summary of operation
// [R1] Edit enable falling starts duplicate destination scan
// [R2] Duplicate found raises visible alarm output
// [R3] Per-input range of 5, 10, 20, 30 V
// [R4] Comparator high selects high, else low value
// [R5] Two value pairs, own destinations, same comparator
// [R6] Zero reads low, any nonzero reads high
// [R7] Offset full percentage always means ten volts
// [R8] Offset is added before scaling
// [R9] Comparator uses range-limited raw input only
// [R10] Factor 1.0000 maps full range to 100%; the code gives 99.99% at full positive range
// [R11] Linear result clamped between max and min
// [R12] Linear destination any slot 000 to 720
// [R13] Each logic output destination slot 000-720
// [R14] Second logic destination resets to slot 400
// [R15] High or low values may come from slots
// [R16] Slot 400 disables output, others enable it
// [R17] High only when input strictly above threshold
// [R18] Results recomputed and written each scan
module uic_top (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [15:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [15:0]               reg_rdata,
    output logic      [2:0]                ain_sel,
    input  wire logic signed [15:0]        ain_mv,
    output logic                           slot_wr_en,
    output logic      [9:0]                slot_wr_addr,
    output logic signed [15:0]             slot_wr_data,
    output logic                           slot_rd_req,
    output logic      [9:0]                slot_rd_addr,
    input  wire logic signed [15:0]        slot_rd_data,
    output logic                           duplicate_destination_alarm,
    output logic                           irq
);
    // Configuration storage, one entry per input or per link.
    logic        [1:0]  range_r   [8];
    logic signed [15:0] offset_r  [8];
    logic signed [15:0] scale_r   [8];
    logic signed [15:0] max_r     [8];
    logic signed [15:0] min_r     [8];
    logic signed [15:0] val_r     [8][4];
    logic signed [15:0] thresh_r  [8];
    logic        [3:0]  dyn_r     [8];
    logic        [9:0]  dest_r    [24];
    logic               edit_en_r;
    logic [2:0]         status_r;
    logic [2:0]         mask_r;
    logic [7:0]         cmp_hist_r;
    logic [7:0]         op1_logic_r;
    logic [9:0]         conflict_slot_r;

    // Scan state.
    uic_pkg::uic_scan_t state_r;
    logic        [2:0]  idx_r;
    logic signed [15:0] v_r;
    logic               cmp_r;
    logic               slot_rd_req_q;

    // Conflict checker state.
    logic               chk_busy_r;
    logic [4:0]         chk_i_r;
    logic [4:0]         chk_j_r;

    // Address decode.
    wire        in_sel   = ~reg_addr[7];
    wire [2:0]  in_idx   = reg_addr[6:4];
    wire [3:0]  fld      = reg_addr[3:0];
    wire        wr_in    = reg_wr & in_sel;
    wire [4:0]  dest_k   = 5'(in_idx * 3) + 5'(fld - uic_pkg::F_LIN_DEST);
    wire        fld_dest = fld >= uic_pkg::F_LIN_DEST
                         && fld <= uic_pkg::F_OP2_DEST;
    wire        slot_ok  = reg_wdata[9:0] <= uic_pkg::SLOT_MAX;
    wire        wr_dest  = wr_in & fld_dest & edit_en_r & slot_ok; // R12 R13
    wire        chk_go   = reg_wr & (reg_addr == uic_pkg::A_CTRL)
                         & edit_en_r & ~reg_wdata[0];              // R1

    // Range limiting of the raw sample; also feeds the comparator.
    wire signed [15:0] rng_mv = uic_pkg::RANGE_MV[range_r[idx_r]]; // R3
    wire signed [15:0] sat_mv = (ain_mv > rng_mv)  ? rng_mv :
                                (ain_mv < -rng_mv) ? -rng_mv : ain_mv;
    wire               cmp_now = sat_mv > thresh_r[idx_r];        // R9 R17

    // Offset in 0.01 % equals mV because 100 % is always 10 V.
    wire signed [17:0] lin_sum = 18'(v_r) + 18'(offset_r[idx_r]); // R7 R8
    // Percent = sum * factor / range; the divide is a reciprocal multiply.
    wire signed [63:0] lin_prod = 64'(lin_sum) * 64'(scale_r[idx_r])
        * 64'(uic_pkg::RANGE_RECIP[range_r[idx_r]]);               // R10
    wire signed [63:0] lin_raw = lin_prod >>> uic_pkg::RECIP_SHIFT;
    wire signed [63:0] lin_hi  = (lin_raw > 64'(max_r[idx_r]))
                               ? 64'(max_r[idx_r]) : lin_raw;
    wire signed [15:0] lin_out = (lin_hi < 64'(min_r[idx_r]))
                               ? min_r[idx_r] : lin_hi[15:0];      // R11

    // Logic pair selection: pair p uses value 2p (high) or 2p+1 (low).
    wire        pair2    = (state_r == uic_pkg::SC_OP1);
    wire        op2      = (state_r == uic_pkg::SC_OP2);
    wire [1:0]  sel_val  = {pair2, ~cmp_r};                        // R4 R5
    wire        sel_dyn  = dyn_r[idx_r][sel_val];                  // R15
    wire signed [15:0] sel_fixed = val_r[idx_r][sel_val];
    wire signed [15:0] op_val = slot_rd_req_q ? slot_rd_data
                              : val_r[idx_r][{op2, ~cmp_r}];
    wire [4:0]  lin_k    = 5'(idx_r * 3);
    wire [4:0]  op_k     = lin_k + (op2 ? 5'h02 : 5'h01);
    wire        write_lin = state_r == uic_pkg::SC_LIN;
    wire        write_op  = pair2 | op2;
    wire [9:0]  out_dest  = write_lin ? dest_r[lin_k] : dest_r[op_k];
    wire        out_live  = out_dest != uic_pkg::SLOT_DISCONNECT;  // R16

    // Conflict comparison of link i against link j.
    wire        chk_hit  = chk_busy_r
                         && dest_r[chk_i_r] == dest_r[chk_j_r]
                         && dest_r[chk_i_r] != uic_pkg::SLOT_DISCONNECT;
    wire        chk_last = chk_j_r == 5'(uic_pkg::LINKS - 1)
                         && chk_i_r == 5'(uic_pkg::LINKS - 2);
    wire        scan_end = op2 && idx_r == 3'h7;

    // Sticky events; a set in the same cycle beats a write-one clear.
    wire [2:0]  ev_set   = {chk_busy_r & chk_last, scan_end, chk_hit};
    wire [2:0]  ev_clr   = (reg_wr && reg_addr == uic_pkg::A_STATUS)
                         ? reg_wdata[2:0] : 3'h0;

    // Read mux, unmapped addresses return zero.
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (in_sel) begin
            unique case (fld)
                uic_pkg::F_RANGE:     rd_mux = {14'h0, range_r[in_idx]};
                uic_pkg::F_OFFSET:    rd_mux = offset_r[in_idx];
                uic_pkg::F_SCALE:     rd_mux = scale_r[in_idx];
                uic_pkg::F_CLAMP_MAX: rd_mux = max_r[in_idx];
                uic_pkg::F_CLAMP_MIN: rd_mux = min_r[in_idx];
                uic_pkg::F_HI1:       rd_mux = val_r[in_idx][0];
                uic_pkg::F_LO1:       rd_mux = val_r[in_idx][1];
                uic_pkg::F_HI2:       rd_mux = val_r[in_idx][2];
                uic_pkg::F_LO2:       rd_mux = val_r[in_idx][3];
                uic_pkg::F_THRESH:    rd_mux = thresh_r[in_idx];
                uic_pkg::F_LIN_DEST, uic_pkg::F_OP1_DEST,
                uic_pkg::F_OP2_DEST:  rd_mux = {6'h0, dest_r[dest_k]};
                uic_pkg::F_DYN_MASK:  rd_mux = {12'h0, dyn_r[in_idx]};
                default:              rd_mux = 16'h0000;
            endcase
        end else begin
            unique case (reg_addr)
                uic_pkg::A_CTRL:     rd_mux = {15'h0, edit_en_r};
                uic_pkg::A_STATUS:   rd_mux = {13'h0, status_r};
                uic_pkg::A_MASK:     rd_mux = {13'h0, mask_r};
                uic_pkg::A_LOGIC:    rd_mux = {op1_logic_r, cmp_hist_r};
                uic_pkg::A_CONFLICT: rd_mux = {chk_busy_r, 5'h0,
                                               conflict_slot_r};
                default:             rd_mux = 16'h0000;
            endcase
        end
    end

    // Per-input configuration writes; link edits only inside a session.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int n = 0; n < 8; n++) begin
                range_r[n]  <= uic_pkg::RANGE_RST;
                offset_r[n] <= uic_pkg::ZERO_RST;
                scale_r[n]  <= uic_pkg::SCALE_RST;
                max_r[n]    <= uic_pkg::MAX_RST;
                min_r[n]    <= uic_pkg::MIN_RST;
                val_r[n][0] <= uic_pkg::HI_RST;
                val_r[n][1] <= uic_pkg::ZERO_RST;
                val_r[n][2] <= uic_pkg::HI_RST;
                val_r[n][3] <= uic_pkg::ZERO_RST;
                thresh_r[n] <= uic_pkg::ZERO_RST;
                dyn_r[n]    <= 4'h0;
                dest_r[3*n]   <= uic_pkg::LIN_DEST_RST[n];
                dest_r[3*n+1] <= uic_pkg::OP1_DEST_RST[n];
                dest_r[3*n+2] <= uic_pkg::SLOT_DISCONNECT; // R14
            end
        end else if (wr_in) begin
            unique case (fld)
                uic_pkg::F_RANGE:     range_r[in_idx]  <= reg_wdata[1:0];
                uic_pkg::F_OFFSET:    offset_r[in_idx] <= reg_wdata;
                uic_pkg::F_SCALE:     scale_r[in_idx]  <= reg_wdata;
                uic_pkg::F_CLAMP_MAX: max_r[in_idx]    <= reg_wdata;
                uic_pkg::F_CLAMP_MIN: min_r[in_idx]    <= reg_wdata;
                uic_pkg::F_HI1:       val_r[in_idx][0] <= reg_wdata;
                uic_pkg::F_LO1:       val_r[in_idx][1] <= reg_wdata;
                uic_pkg::F_HI2:       val_r[in_idx][2] <= reg_wdata;
                uic_pkg::F_LO2:       val_r[in_idx][3] <= reg_wdata;
                uic_pkg::F_THRESH:    thresh_r[in_idx] <= reg_wdata;
                uic_pkg::F_DYN_MASK:  dyn_r[in_idx]    <= reg_wdata[3:0];
                default: begin
                    if (wr_dest) begin
                        dest_r[dest_k] <= reg_wdata[9:0];
                    end
                end
            endcase
        end
    end

    // Global control, events, interrupt and bus read data.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            edit_en_r <= 1'b0;
            status_r  <= 3'h0;
            mask_r    <= 3'h0;
            irq       <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == uic_pkg::A_CTRL) begin
                edit_en_r <= reg_wdata[0];
            end
            if (reg_wr && reg_addr == uic_pkg::A_MASK) begin
                mask_r <= reg_wdata[2:0];
            end
            status_r  <= (status_r & ~ev_clr) | ev_set;
            irq       <= |(status_r & mask_r);
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // Pairwise link scan after a session ends; the first hit is kept.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_busy_r      <= 1'b0;
            chk_i_r         <= 5'h00;
            chk_j_r         <= 5'h01;
            conflict_slot_r <= 10'h000;
            duplicate_destination_alarm <= 1'b0;
        end else if (chk_go) begin
            chk_busy_r <= 1'b1;                                    // R1
            chk_i_r    <= 5'h00;
            chk_j_r    <= 5'h01;
            duplicate_destination_alarm <= 1'b0;
        end else if (chk_busy_r) begin
            if (chk_hit && !duplicate_destination_alarm) begin
                conflict_slot_r <= dest_r[chk_i_r];
            end
            if (chk_hit) begin
                duplicate_destination_alarm <= 1'b1;               // R2
            end
            if (chk_last) begin
                chk_busy_r <= 1'b0;
            end else if (chk_j_r == 5'(uic_pkg::LINKS - 1)) begin
                chk_i_r <= chk_i_r + 5'h01;
                chk_j_r <= chk_i_r + 5'h02;
            end else begin
                chk_j_r <= chk_j_r + 5'h01;
            end
        end
    end

    // Scan sequencer: one input per six-cycle step, every output not linked to slot 400 rewritten each pass.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= uic_pkg::SC_SAMPLE;
            idx_r   <= 3'h0;
            v_r     <= 16'sh0000;
            cmp_r   <= 1'b0;
        end else begin
            unique case (state_r)
                uic_pkg::SC_SAMPLE: begin
                    v_r     <= sat_mv;
                    cmp_r   <= cmp_now;                            // R17
                    state_r <= uic_pkg::SC_LIN;
                end
                uic_pkg::SC_LIN:    state_r <= uic_pkg::SC_FETCH1;
                uic_pkg::SC_FETCH1: state_r <= uic_pkg::SC_OP1;
                uic_pkg::SC_OP1:    state_r <= uic_pkg::SC_FETCH2;
                uic_pkg::SC_FETCH2: state_r <= uic_pkg::SC_OP2;
                uic_pkg::SC_OP2: begin
                    idx_r   <= idx_r + 3'h1;                       // R18
                    state_r <= uic_pkg::SC_SAMPLE;
                end
            endcase
        end
    end

    // Slot port, logic-state snapshot and input selector flops.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_wr_en    <= 1'b0;
            slot_wr_addr  <= 10'h000;
            slot_wr_data  <= 16'sh0000;
            slot_rd_req   <= 1'b0;
            slot_rd_addr  <= 10'h000;
            slot_rd_req_q <= 1'b0;
            ain_sel       <= 3'h0;
            cmp_hist_r    <= 8'h00;
            op1_logic_r   <= 8'h00;
        end else begin
            slot_wr_en    <= (write_lin | write_op) & out_live;    // R16
            slot_wr_addr  <= out_dest;
            slot_wr_data  <= write_lin ? lin_out : op_val;         // R18
            // A live value is fetched only for the side the comparator picks.
            slot_rd_req   <= (write_lin | pair2) & sel_dyn;        // R15
            slot_rd_addr  <= sel_fixed[9:0];
            slot_rd_req_q <= slot_rd_req;
            ain_sel       <= op2 ? idx_r + 3'h1 : idx_r;
            if (state_r == uic_pkg::SC_SAMPLE) begin
                cmp_hist_r[idx_r] <= cmp_now;
            end
            if (state_r == uic_pkg::SC_OP1) begin
                op1_logic_r[idx_r] <= op_val != 16'sh0000;        // R6
            end
        end
    end

    // Checks on the scan and conflict paths.
    sequence s_fetch_dyn;
        slot_rd_req ##1 state_r == uic_pkg::SC_OP1
                        || state_r == uic_pkg::SC_OP2;
    endsequence

    a_no_disc_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        slot_wr_en |-> slot_wr_addr != uic_pkg::SLOT_DISCONNECT) // R16
        else $error("write issued to the disconnect slot");
    a_lin_clamped: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(state_r) == uic_pkg::SC_LIN && slot_wr_en
        |-> slot_wr_data >= $past(min_r[idx_r])
            || slot_wr_data == $past(min_r[idx_r])) // R11
        else $error("linear result below minimum clamp");
    a_dyn_data_used: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_fetch_dyn ##1 slot_wr_en |-> slot_wr_data == $past(slot_rd_data))
        // R15
        else $error("fetched live value not forwarded");
    a_check_starts: assert property (@(posedge sys_clk) disable iff (!rst_n)
        chk_go |=> chk_busy_r && !duplicate_destination_alarm) // R1
        else $error("conflict scan did not start");
    a_check_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
        chk_go |=> chk_busy_r [*8])
        else $error("conflict scan ended too early");
    a_alarm_raise: assert property (@(posedge sys_clk) disable iff (!rst_n)
        chk_hit && !chk_go |=> duplicate_destination_alarm) // R2
        else $error("duplicate not flagged");
    a_cmp_strict: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == uic_pkg::SC_SAMPLE && sat_mv == thresh_r[idx_r]
        |=> !cmp_r) // R17
        else $error("equal input read as high");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
        |(status_r & mask_r) |=> irq)
        else $error("interrupt not raised for pending event");
    a_scan_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == uic_pkg::SC_SAMPLE |-> ##6 state_r
        == uic_pkg::SC_SAMPLE) // R18
        else $error("scan step not six cycles");
endmodule : uic_top

// *** testbench/uic_far_model.sv ***
// Far side model: terminal voltages of the eight inputs and the slot store.
`timescale 1ns/10ps
module uic_far_model (
    input  wire logic               sys_clk,
    input  wire logic [2:0]         ain_sel,
    output logic signed [15:0]      ain_mv,
    input  wire logic               slot_wr_en,
    input  wire logic [9:0]         slot_wr_addr,
    input  wire logic signed [15:0] slot_wr_data,
    input  wire logic               slot_rd_req,
    input  wire logic [9:0]         slot_rd_addr,
    output logic signed [15:0]      slot_rd_data
);
    logic signed [15:0] mv    [8];
    logic signed [15:0] slots [1024];
    int                 wcnt  [1024];
    // Start quiet so no unknown input voltage or idle read data reaches the design; the slot store starts unknown.
    initial begin
        foreach (mv[i]) mv[i] = 16'sh0000;
        foreach (wcnt[i]) wcnt[i] = 0;
        slot_rd_data = 16'sh0000;
    end
    // The terminal shows the voltage of whichever input is selected.
    assign ain_mv = mv[ain_sel];
    // Reads answer next cycle only; idle read data toggles.
    always @(posedge sys_clk) begin
        slot_rd_data <= slot_rd_req ? slots[slot_rd_addr] : ~slot_rd_data;
        if (slot_wr_en) begin
            slots[slot_wr_addr] <= slot_wr_data;
            wcnt[slot_wr_addr]  <= wcnt[slot_wr_addr] + 1;
        end
    end
endmodule : uic_far_model

// *** testbench/universal_input_conditioner_tb_top.sv ***
// Self-checking bench for the universal input conditioner.
`timescale 1ns/10ps
module universal_input_conditioner_tb_top;
    logic               sys_clk, rst_n, reg_wr, reg_rd;
    logic [7:0]         reg_addr;
    logic [15:0]        reg_wdata, reg_rdata, d;
    logic [2:0]         ain_sel;
    logic signed [15:0] ain_mv, slot_wr_data, slot_rd_data, hv;
    logic               slot_wr_en, slot_rd_req, alarm, irq;
    logic [9:0]         slot_wr_addr, slot_rd_addr;
    logic [31:0]        seed = 32'h0000002E;
    int                 error_cnt = 0;
    int                 comparisons = 0;
    // Reset values of fields 0 to 9 of every input.
    localparam logic [15:0] DFLT [10] = '{16'h0001, 16'h0000, 16'h2710,
        16'h2710, 16'hD8F0, 16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
    uic_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ain_sel(ain_sel), .ain_mv(ain_mv),
        .slot_wr_en(slot_wr_en), .slot_wr_addr(slot_wr_addr),
        .slot_wr_data(slot_wr_data), .slot_rd_req(slot_rd_req),
        .slot_rd_addr(slot_rd_addr), .slot_rd_data(slot_rd_data),
        .duplicate_destination_alarm(alarm), .irq(irq));
    uic_far_model u_far (.sys_clk(sys_clk), .ain_sel(ain_sel),
        .ain_mv(ain_mv), .slot_wr_en(slot_wr_en), .slot_wr_addr(slot_wr_addr),
        .slot_wr_data(slot_wr_data), .slot_rd_req(slot_rd_req),
        .slot_rd_addr(slot_rd_addr), .slot_rd_data(slot_rd_data));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [7:0] fa(input int i, input logic [3:0] f);
        return {1'b0, 3'(i), f};
    endfunction : fa
    // Limit, offset, scale, floor divide by range, then clamp.
    function automatic int lin_exp(input int v, off, sc, rg, mx);
        int r, q;
        r = int'(uic_pkg::RANGE_MV[rg]);
        v = (v > r) ? r : ((v < -r) ? -r : v);
        q = (v + off) * sc;
        q = (q >= 0) ? q / r : -((-q + r - 1) / r);
        return (q > mx) ? mx : ((q < -mx) ? -mx : q);
    endfunction : lin_exp
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [15:0] w);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask : rd
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // Free-running 20 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Watchdog, about nine times the expected run.
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        test_done();
    end
    // Main sequence; 100 cycles cover two scan passes.
    initial begin
        int v, off, sc, rg, mx;
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            for (int f = 0; f < 10; f++) begin
                rd(fa(i, 4'(f)), d);
                check(d, DFLT[f]);
            end
            rd(fa(i, uic_pkg::F_LIN_DEST), d);
            check(d, 16'(uic_pkg::LIN_DEST_RST[i]));
            rd(fa(i, uic_pkg::F_OP1_DEST), d);
            check(d, 16'(uic_pkg::OP1_DEST_RST[i]));
            rd(fa(i, uic_pkg::F_OP2_DEST), d);
            check(d, 16'h0190);
        end
        rd(8'h85, d);
        check(d, 16'h0000);
        $display("test defaults done");
        // Linear path on input 0, whose link goes to slot 63.
        for (int k = 0; k < 8; k++) begin
            rg = int'(rnd() % 4);
            v = int'($signed(rnd() % 62001)) - 31000;
            off = int'(rnd() % 20001) - 10000;
            sc = int'(rnd() % 60001) - 30000;
            mx = 2000 + int'(rnd() % 8001);
            if (k == 0) {rg, v, off, sc, mx} = {32'd3, 32'd30000, 32'd0,
                32'd10000, 32'd10000};
            if (k == 1) {rg, v, sc} = {32'd0, -32'sd31000, -32'sd10000};
            wr(fa(0, uic_pkg::F_RANGE), 16'(rg));
            wr(fa(0, uic_pkg::F_OFFSET), 16'(off));
            wr(fa(0, uic_pkg::F_SCALE), 16'(sc));
            wr(fa(0, uic_pkg::F_CLAMP_MAX), 16'(mx));
            wr(fa(0, uic_pkg::F_CLAMP_MIN), 16'(-mx));
            u_far.mv[0] <= 16'(v);
            repeat (100) @(posedge sys_clk);
            hv = u_far.slots[63];
            // The reciprocal divide may be one lsb off.
            v = lin_exp(v, off, sc, rg, mx);
            check(16'(hv >= v - 1 && hv <= v + 1), 16'h0001);
        end
        check(16'(u_far.wcnt[400]), 16'h0000);
        $display("test linear done");
        // Logic path on input 7: op1 to slot 49, op2 moved to slot 100.
        wr(uic_pkg::A_CTRL, 16'h0001);
        wr(fa(7, uic_pkg::F_OP2_DEST), 16'h0064);
        wr(fa(7, uic_pkg::F_OP2_DEST), 16'h02D1);
        rd(fa(7, uic_pkg::F_OP2_DEST), d);
        check(d, 16'h0064);
        wr(fa(7, uic_pkg::F_THRESH), 16'hFC18);
        wr(fa(7, uic_pkg::F_OFFSET), 16'h1388);
        wr(fa(7, uic_pkg::F_SCALE), 16'hD8F0);
        wr(fa(7, uic_pkg::F_HI1), 16'hFFE7);
        wr(fa(7, uic_pkg::F_HI2), 16'h004D);
        wr(fa(7, uic_pkg::F_LO2), 16'h0021);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) wr(fa(7, uic_pkg::F_DYN_MASK), 16'h0001);
            if (k == 2) wr(fa(7, uic_pkg::F_HI1), 16'h02BC);
            u_far.slots[700] <= 16'(1234 * k);
            u_far.mv[7] <= (k == 0) ? 16'hFC18 : 16'hFC19;
            repeat (100) @(posedge sys_clk);
            hv = (k == 0) ? 16'h0000 : ((k == 1) ? 16'hFFE7 : 16'(1234 * k));
            check(u_far.slots[49], hv);
            check(u_far.slots[100], (k == 0) ? 16'h0021 : 16'h004D);
            rd(uic_pkg::A_LOGIC, d);
            check({d[15], d[7]}, (k == 0) ? 16'h0000 : 16'h0003);
        end
        $display("test logic done");
        // Two links onto slot 100, then end the edit session.
        wr(fa(6, uic_pkg::F_OP2_DEST), 16'h0064);
        wr(uic_pkg::A_MASK, 16'h0005);
        wr(uic_pkg::A_CTRL, 16'h0000);
        repeat (290) @(posedge sys_clk);
        check(16'(alarm), 16'h0001);
        rd(uic_pkg::A_CONFLICT, d);
        check(d, 16'h0064);
        check(16'(irq), 16'h0001);
        wr(uic_pkg::A_MASK, 16'h0000);
        repeat (3) @(posedge sys_clk);
        check(16'(irq), 16'h0000);
        wr(uic_pkg::A_MASK, 16'h0005);
        wr(uic_pkg::A_STATUS, 16'h0005);
        repeat (3) @(posedge sys_clk);
        check(16'(irq), 16'h0000);
        check(16'(alarm), 16'h0001);
        // Remove the duplicate; many links on slot 400 must not count.
        wr(uic_pkg::A_CTRL, 16'h0001);
        wr(fa(6, uic_pkg::F_OP2_DEST), 16'h0190);
        wr(uic_pkg::A_CTRL, 16'h0000);
        repeat (290) @(posedge sys_clk);
        check(16'(alarm), 16'h0000);
        wr(fa(6, uic_pkg::F_OP2_DEST), 16'h0064);
        rd(fa(6, uic_pkg::F_OP2_DEST), d);
        check(d, 16'h0190);
        $display("test conflict done");
        test_done();
    end
endmodule : universal_input_conditioner_tb_top
